//--- include/rps_div_if.sv
// Purpose: request and answer of the shared position divider
// Assumes: num and den stay stable while a division runs
// Notes: done is a one cycle pulse
`default_nettype none

interface rps_div_if;
	import rps_pkg::*;
	logic start;
	logic [DIV_W-1:0] num;
	logic [FSC_W-1:0] den;
	logic done;
	logic [FSC_W-1:0] quo;
	modport req (output start, num, den, input done, quo);
	modport srv (input start, num, den, output done, quo);
endinterface

`default_nettype wire

//--- include/rps_pkg.sv
// Purpose: shared constants and types for resolver position scaling
// Assumes: widths follow the documented parameter ranges
// Notes: counts per revolution of the fine resolver are fixed at 2^16
`default_nettype none

package rps_pkg;
	// ==================================================================
	// widths
	localparam int FSC_W = 27;
	localparam int TRN_W = 11;
	localparam int ANG_W = 16;
	localparam int DIV_W = 56;
	localparam logic [5:0] DIV_STEPS = 6'h38;

	// ==================================================================
	// configuration limits and defaults
	localparam logic [13:0] REF_MV_MIN = 14'h0320;
	localparam logic [13:0] REF_MV_MAX = 14'h2ee0;
	localparam logic [13:0] REF_MV_DEF = 14'h0cb2;
	localparam logic [13:0] REF_HZ_MIN = 14'h0190;
	localparam logic [13:0] REF_HZ_MAX = 14'h2710;
	localparam logic [13:0] REF_HZ_DEF = 14'h09c4;
	localparam logic [8:0] RATIO_MIN = 9'h00a;
	localparam logic [8:0] RATIO_MAX = 9'h12c;
	localparam logic [8:0] RATIO_DEF = 9'h05f;

	// ==================================================================
	// setup limits and defaults
	localparam logic [FSC_W-1:0] FSC_MIN = 27'h0000002;
	localparam logic [FSC_W-1:0] FSC_ONE_MAX = 27'h0010000;
	localparam logic [FSC_W-1:0] FSC_DEF = 27'h0000400;
	localparam logic [TRN_W-1:0] TURNS_ONE = 11'h001;
	localparam logic [TRN_W-1:0] TEN = 11'h00a;
	localparam logic [TRN_W-1:0] XT_100 = 11'h064;
	localparam logic [TRN_W-1:0] XT_180 = 11'h0b4;
	localparam logic [TRN_W-1:0] XT_1000 = 11'h3e8;
	localparam logic [TRN_W-1:0] XT_1800 = 11'h708;
	localparam logic [TRN_W-1:0] XT_FOR_MIN = 11'h002;
	localparam logic [TRN_W-1:0] XT_FOR_MAX = 11'h080;
	localparam logic [ANG_W-1:0] ANG_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		RPS_BLK_CAL, RPS_BLK_CFG, RPS_BLK_SETUP, RPS_BLK_ALIGN, RPS_BLK_MEAS
	} rps_blk_t;

	typedef enum logic [1:0] {XD_SINGLE, XD_MATCHED, XD_FOREIGN} rps_xd_t;
endpackage

`default_nettype wire

//--- rtl/rps_chk.sv
// Purpose: range check of one transducer setup block
// Assumes: pure combinational, read on the block strobe
// Notes: division based checks are small since turns fit 11 bits
`default_nettype none

module rps_chk
	import rps_pkg::*;
(
	input wire logic [1:0] kind_i,
	input wire logic [TRN_W-1:0] xtype_i,
	input wire logic [TRN_W-1:0] turns_i,
	input wire logic [FSC_W-1:0] fsc_i,
	input wire logic [FSC_W-1:0] preset_i,
	output logic ok_o
);
	logic tdiv;
	logic tenx;
	logic typ_ok;
	logic [FSC_W-1:0] lim;
	logic [FSC_W+3:0] fsc_x;

	// ==================================================================
	// turns must divide the transducer type, limit scales with turns
	always_comb begin
		tdiv = (turns_i != '0) && ((xtype_i % turns_i) == '0); // see [RULE12] see [RULE16]
		tenx = (xtype_i == XT_1000) || (xtype_i == XT_1800);
		lim = {turns_i, ANG_ZERO}; // see [RULE17]
		fsc_x = {4'h0, fsc_i};
		typ_ok = 1'b0;
		case (rps_xd_t'(kind_i))
			XD_SINGLE: begin
				typ_ok = 1'b1;
				lim = FSC_ONE_MAX; // see [RULE8]
			end
			XD_MATCHED: begin
				typ_ok = ((xtype_i == XT_100) || (xtype_i == XT_180) || tenx) // see [RULE10]
					&& tdiv && (!tenx || ((turns_i % TEN) == '0)); // see [RULE12]
				if (tenx) begin
					fsc_x = fsc_i * 31'h0000000a; // see [RULE13]
				end
			end
			XD_FOREIGN: begin
				typ_ok = (xtype_i >= XT_FOR_MIN) && (xtype_i <= XT_FOR_MAX) && tdiv; // see [RULE15]
			end
			default: typ_ok = 1'b0;
		endcase
		ok_o = typ_ok && (fsc_i >= FSC_MIN) && (fsc_x <= {4'h0, lim}) // see [RULE13]
			&& (preset_i < fsc_i); // see [RULE9]
	end
endmodule

`default_nettype wire

//--- rtl/rps_div.sv
// Purpose: serial restoring divider for position scaling
// Assumes: quotient fits FSC_W bits
// Notes: one quotient bit per clock, DIV_STEPS clocks per answer
`default_nettype none

module rps_div
	import rps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	rps_div_if.srv dv
);
	logic [DIV_W-1:0] num_q;
	logic [FSC_W:0] rem_q;
	logic [5:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [FSC_W:0] trial;

	// ==================================================================
	// shift one dividend bit into the remainder
	always_comb begin
		trial = {rem_q[FSC_W-1:0], num_q[DIV_W-1]};
	end

	// the quotient bits refill the dividend register from the bottom
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			num_q <= '0;
			rem_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (dv.start && !busy_q) begin
				num_q <= dv.num;
				rem_q <= '0;
				cnt_q <= DIV_STEPS;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (trial >= {1'b0, dv.den}) begin
					rem_q <= trial - {1'b0, dv.den};
					num_q <= {num_q[DIV_W-2:0], 1'b1};
				end else begin
					rem_q <= trial;
					num_q <= {num_q[DIV_W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign dv.done = done_q;
	assign dv.quo = num_q[FSC_W-1:0];
endmodule

`default_nettype wire

//--- rtl/rps_top.sv
// Purpose: parameter blocks and position scaling for a two channel resolver interface
// Assumes: demodulated angles and coarse turn index arrive on the core clock
// Notes: one shared serial divider scales both channels in turn
`default_nettype none

// What this block does
// [RULE1] parameter sets taken only as whole blocks
// [RULE2] reference amplitude 800 to 12000 mV, default 3250
// [RULE3] reference frequency 400 to 10000 Hz, default 2500
// [RULE4] per channel winding gain ratio 10..300, default 95
// [RULE5] reference role selects master or slave
// [RULE6] faults self clear or latch until host clears
// [RULE7] direction bit picks increasing rotation sense
// [RULE8] single resolver full scale 2 to 65536
// [RULE9] preset below full scale, applied on command
// [RULE10] matched dual type only 100,180,1000,1800
// [RULE11] dual position wraps after programmed turns
// [RULE12] turn count limited by matched type
// [RULE13] matched full scale bounded by turns multiplier
// [RULE14] foreign dual gearing reduction or vernier
// [RULE15] foreign maximum turns 2 to 128
// [RULE16] foreign turn count divides maximum turns
// [RULE17] foreign full scale 2 to 65536 times turns
// [RULE18] alignment computes hidden coarse offset, foreign only
// [RULE19] preset command stores hidden position offset
// [RULE20] measurement block drives indicators and fault clear
// [RULE21] bad block rejected, old kept, error flagged
module rps_top
	import rps_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire logic BLK_STB_I,
	input wire logic [2:0] BLK_KIND_I,
	input wire logic [15:0] CAL_TRIM_I,
	input wire logic [13:0] REF_MV_I,
	input wire logic [13:0] REF_HZ_I,
	input wire logic [8:0] RATIO0_I,
	input wire logic [8:0] RATIO1_I,
	input wire logic SLAVE_I,
	input wire logic SET_CH_I,
	input wire logic [1:0] XD_KIND_I,
	input wire logic LATCH_I,
	input wire logic DIR_I,
	input wire logic GEAR_I,
	input wire logic [TRN_W-1:0] XTYPE_I,
	input wire logic [TRN_W-1:0] TURNS_I,
	input wire logic [FSC_W-1:0] FSC_I,
	input wire logic [FSC_W-1:0] PRESET_I,
	input wire logic MEAS_CH_I,
	input wire logic MEAS_PRESET_I,
	input wire logic MEAS_CLR_I,
	input wire logic MEAS_LED_I,
	input wire logic [ANG_W-1:0] ANGLE0_I,
	input wire logic [ANG_W-1:0] ANGLE1_I,
	input wire logic [TRN_W-1:0] COARSE_TURN_I,
	input wire logic [1:0] FAULT_I,
	output logic [15:0] CAL_TRIM_O,
	output logic [13:0] REF_MV_O,
	output logic [13:0] REF_HZ_O,
	output logic [8:0] RATIO0_O,
	output logic [8:0] RATIO1_O,
	output logic SLAVE_O,
	output logic VERNIER_O,
	output logic [FSC_W-1:0] POS0_O,
	output logic [FSC_W-1:0] POS1_O,
	output logic [1:0] FAULT_O,
	output logic [1:0] LED_O,
	output logic CFG_ERR_O,
	output logic ALIGNED_O
);
	typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_APPLY} rps_st_t;

	rps_st_t st_q;
	rps_blk_t blk_kind;
	logic ch_q;
	logic chk_ok;
	logic blk_ok;
	logic stb_ok;
	rps_xd_t kind_q [2];
	logic latch_q [2];
	logic dir_q [2];
	logic [TRN_W-1:0] xtype_q [2];
	logic [TRN_W-1:0] turns_q [2];
	logic [FSC_W-1:0] fsc_q [2];
	logic [FSC_W-1:0] preset_q [2];
	logic [FSC_W-1:0] off_q [2];
	logic [FSC_W-1:0] pos_q [2];
	logic pend_q [2];
	logic fault_q [2];
	logic led_q [2];
	logic lvl_q [2];
	logic [TRN_W-1:0] align_off_q;
	logic start_q;
	logic [DIV_W-1:0] num_q;
	logic [FSC_W-1:0] den_q;
	logic [FSC_W-1:0] raw_q;
	logic [TRN_W-1:0] ct_diff;
	logic [TRN_W-1:0] turn_sel;
	logic [DIV_W-1:0] num_d;
	logic [FSC_W-1:0] fsc_c;
	logic [FSC_W-1:0] raw_c;
	logic [FSC_W-1:0] rd;
	logic [FSC_W-1:0] off_c;
	logic [FSC_W:0] sum;
	logic [FSC_W-1:0] pos_new;
	logic [FSC_W-1:0] off_new;

	rps_div_if dv();

	// ==================================================================
	// block acceptance
	assign blk_kind = rps_blk_t'(BLK_KIND_I);

	rps_chk u_chk (
		.kind_i(XD_KIND_I),
		.xtype_i(XTYPE_I),
		.turns_i(TURNS_I),
		.fsc_i(FSC_I),
		.preset_i(PRESET_I),
		.ok_o(chk_ok)
	);

	// every field of a block is checked before any of it is stored
	always_comb begin
		blk_ok = 1'b0;
		case (blk_kind)
			RPS_BLK_CAL: blk_ok = 1'b1;
			RPS_BLK_CFG: begin
				blk_ok = (REF_MV_I >= REF_MV_MIN) && (REF_MV_I <= REF_MV_MAX) // see [RULE2]
					&& (REF_HZ_I >= REF_HZ_MIN) && (REF_HZ_I <= REF_HZ_MAX) // see [RULE3]
					&& (RATIO0_I >= RATIO_MIN) && (RATIO0_I <= RATIO_MAX) // see [RULE4]
					&& (RATIO1_I >= RATIO_MIN) && (RATIO1_I <= RATIO_MAX);
			end
			// dual transducers live on channel 0 only
			RPS_BLK_SETUP: blk_ok = chk_ok && (!SET_CH_I || (XD_KIND_I == XD_SINGLE));
			RPS_BLK_ALIGN: blk_ok = (kind_q[0] == XD_FOREIGN); // see [RULE18]
			RPS_BLK_MEAS: blk_ok = 1'b1;
			default: blk_ok = 1'b0;
		endcase
	end

	assign stb_ok = BLK_STB_I && blk_ok; // see [RULE1]

	// error flag follows the last block: set on reject, cleared on accept
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CFG_ERR_O <= 1'b0;
		end else if (BLK_STB_I) begin
			CFG_ERR_O <= !blk_ok; // see [RULE21]
		end
	end

	// ==================================================================
	// calibration and configuration sets
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CAL_TRIM_O <= '0;
			REF_MV_O <= REF_MV_DEF;
			REF_HZ_O <= REF_HZ_DEF;
			RATIO0_O <= RATIO_DEF;
			RATIO1_O <= RATIO_DEF;
			SLAVE_O <= 1'b0;
		end else if (stb_ok && (blk_kind == RPS_BLK_CAL)) begin
			CAL_TRIM_O <= CAL_TRIM_I;
		end else if (stb_ok && (blk_kind == RPS_BLK_CFG)) begin
			REF_MV_O <= REF_MV_I; // see [RULE2]
			REF_HZ_O <= REF_HZ_I; // see [RULE3]
			RATIO0_O <= RATIO0_I; // see [RULE4]
			RATIO1_O <= RATIO1_I;
			SLAVE_O <= SLAVE_I; // see [RULE5]
		end
	end

	// gearing type steers the coarse decoder for channel 0
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			VERNIER_O <= 1'b0;
		end else if (stb_ok && (blk_kind == RPS_BLK_SETUP) && !SET_CH_I) begin
			VERNIER_O <= GEAR_I; // see [RULE14]
		end
	end

	// ==================================================================
	// alignment: capture coarse turn so the current turn reads zero
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			align_off_q <= '0;
			ALIGNED_O <= 1'b0;
		end else if (stb_ok && (blk_kind == RPS_BLK_ALIGN)) begin
			align_off_q <= COARSE_TURN_I % xtype_q[0]; // see [RULE18]
			ALIGNED_O <= 1'b1;
		end else if (stb_ok && (blk_kind == RPS_BLK_SETUP) && !SET_CH_I) begin
			align_off_q <= '0;
			ALIGNED_O <= 1'b0;
		end
	end

	// ==================================================================
	// per channel setup, faults, indicators and preset requests
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic set_hit;
		logic meas_hit;
		logic [2:0] sync_q;

		assign set_hit = stb_ok && (blk_kind == RPS_BLK_SETUP) && (SET_CH_I == 1'(c));
		assign meas_hit = stb_ok && (blk_kind == RPS_BLK_MEAS) && (MEAS_CH_I == 1'(c));

		// setup store; single resolvers always scale over one turn
		always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				kind_q[c] <= XD_SINGLE;
				latch_q[c] <= 1'b0;
				dir_q[c] <= 1'b0;
				xtype_q[c] <= TURNS_ONE;
				turns_q[c] <= TURNS_ONE;
				fsc_q[c] <= FSC_DEF;
				preset_q[c] <= '0;
			end else if (set_hit) begin
				kind_q[c] <= rps_xd_t'(XD_KIND_I);
				latch_q[c] <= LATCH_I; // see [RULE6]
				dir_q[c] <= DIR_I; // see [RULE7]
				xtype_q[c] <= (XD_KIND_I == XD_SINGLE) ? TURNS_ONE : XTYPE_I;
				turns_q[c] <= (XD_KIND_I == XD_SINGLE) ? TURNS_ONE : TURNS_I;
				fsc_q[c] <= FSC_I; // see [RULE8]
				preset_q[c] <= PRESET_I; // see [RULE9]
			end
		end

		// fault pin is asynchronous: accept a level once stages 2 and 3 agree
		always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				sync_q <= '0;
				lvl_q[c] <= 1'b0;
			end else begin
				sync_q <= {sync_q[1:0], FAULT_I[c]};
				if (sync_q[1] == sync_q[2]) begin
					lvl_q[c] <= sync_q[2];
				end
			end
		end

		// an active fault wins over a clear in the same cycle
		always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				fault_q[c] <= 1'b0;
			end else if (lvl_q[c]) begin
				fault_q[c] <= 1'b1;
			end else if (!latch_q[c] || (meas_hit && MEAS_CLR_I)) begin
				fault_q[c] <= 1'b0; // see [RULE6] see [RULE20]
			end
		end

		// indicators on by default until the host switches them
		always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				led_q[c] <= 1'b1;
			end else if (meas_hit) begin
				led_q[c] <= MEAS_LED_I; // see [RULE20]
			end
		end

		// a new request in the acknowledge cycle survives for the next pass
		always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				pend_q[c] <= 1'b0;
			end else if (meas_hit && MEAS_PRESET_I) begin
				pend_q[c] <= 1'b1; // see [RULE9]
			end else if ((st_q == ST_APPLY) && (ch_q == 1'(c))) begin
				pend_q[c] <= 1'b0;
			end
		end
	end

	assign FAULT_O = {fault_q[1], fault_q[0]};
	assign LED_O = {led_q[1], led_q[0]};
	assign POS0_O = pos_q[0];
	assign POS1_O = pos_q[1];

	// ==================================================================
	// dividend: fraction of the wrap span times full scale count
	always_comb begin
		ct_diff = COARSE_TURN_I - align_off_q;
		if (COARSE_TURN_I < align_off_q) begin
			ct_diff = ct_diff + xtype_q[0];
		end
		turn_sel = '0;
		if (!ch_q && (kind_q[0] != XD_SINGLE)) begin
			turn_sel = ct_diff % turns_q[0]; // see [RULE11]
		end
		num_d = DIV_W'({turn_sel, (ch_q ? ANGLE1_I : ANGLE0_I)}) * DIV_W'(fsc_q[ch_q]);
	end

	// sequencer: one channel per pass, divider shared to save area
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_q <= ST_IDLE;
			ch_q <= 1'b0;
			start_q <= 1'b0;
			num_q <= '0;
			den_q <= '0;
			raw_q <= '0;
		end else begin
			start_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					num_q <= num_d;
					den_q <= {turns_q[ch_q], ANG_ZERO}; // see [RULE11]
					start_q <= 1'b1;
					st_q <= ST_DIV;
				end
				ST_DIV: begin
					if (dv.done) begin
						raw_q <= dv.quo;
						st_q <= ST_APPLY;
					end
				end
				ST_APPLY: begin
					ch_q <= ~ch_q;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign dv.start = start_q;
	assign dv.num = num_q;
	assign dv.den = den_q;

	rps_div u_div (
		.clk_i(CORE_CLK_I),
		.rst_b_i(RST_B_I),
		.dv(dv.srv)
	);

	// ==================================================================
	// direction, offset and wrap; a setup change mid-pass is clamped
	always_comb begin
		fsc_c = fsc_q[ch_q];
		raw_c = (raw_q >= fsc_c) ? '0 : raw_q;
		rd = (dir_q[ch_q] && (raw_c != '0)) ? fsc_c - raw_c : raw_c; // see [RULE7]
		off_c = (off_q[ch_q] < fsc_c) ? off_q[ch_q] : '0;
		sum = {1'b0, rd} + {1'b0, off_c};
		pos_new = (sum >= {1'b0, fsc_c}) ? FSC_W'(sum - {1'b0, fsc_c}) : sum[FSC_W-1:0];
		if (preset_q[ch_q] >= rd) begin
			off_new = preset_q[ch_q] - rd; // see [RULE19]
		end else begin
			off_new = FSC_W'({1'b0, preset_q[ch_q]} + {1'b0, fsc_c} - {1'b0, rd});
		end
	end

	// reported position updates once per pass, hidden offset only on a pass with a preset pending
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int i = 0; i < 2; i++) begin
				off_q[i] <= '0;
				pos_q[i] <= '0;
			end
		end else if (st_q == ST_APPLY) begin
			if (pend_q[ch_q]) begin
				off_q[ch_q] <= off_new; // see [RULE19]
				pos_q[ch_q] <= preset_q[ch_q]; // see [RULE9]
			end else begin
				pos_q[ch_q] <= pos_new; // see [RULE8] see [RULE11]
			end
		end
	end

	// ==================================================================
	// assertions
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);

	cfg_reject_a: assert property (BLK_STB_I && !blk_ok |=> CFG_ERR_O // see [RULE21]
		&& $stable(REF_MV_O) && $stable(SLAVE_O) && $stable(VERNIER_O))
		else $error("rejected block changed state");
	whole_block_a: assert property (stb_ok && (blk_kind == RPS_BLK_CFG) // see [RULE1]
		|=> REF_HZ_O == $past(REF_HZ_I) && RATIO1_O == $past(RATIO1_I))
		else $error("config block not stored whole");
	ref_mv_a: assert property (REF_MV_O >= REF_MV_MIN && REF_MV_O <= REF_MV_MAX) // see [RULE2]
		else $error("reference amplitude out of range");
	ref_hz_a: assert property (REF_HZ_O >= REF_HZ_MIN && REF_HZ_O <= REF_HZ_MAX) // see [RULE3]
		else $error("reference frequency out of range");
	gain_ratio_a: assert property (RATIO0_O >= RATIO_MIN && RATIO0_O <= RATIO_MAX) // see [RULE4]
		else $error("gain ratio out of range");
	slave_mode_a: assert property (stb_ok && (blk_kind == RPS_BLK_CFG) // see [RULE5]
		|=> SLAVE_O == $past(SLAVE_I))
		else $error("reference role not taken");
	fault_hold_a: assert property (FAULT_O[1] && latch_q[1] // see [RULE6]
		&& !(stb_ok && blk_kind == RPS_BLK_MEAS && MEAS_CH_I && MEAS_CLR_I) |=> FAULT_O[1])
		else $error("latched fault dropped");
	fault_clear_a: assert property (!latch_q[1] && !lvl_q[1] && !FAULT_I[1] // see [RULE6]
		|=> !FAULT_O[1])
		else $error("self clearing fault stuck");
	pos_wrap_a: assert property ((st_q == ST_APPLY) && !ch_q && $stable(fsc_q[0]) // see [RULE11]
		|=> POS0_O < fsc_q[0])
		else $error("position beyond full scale");
	preset_apply_a: assert property ((st_q == ST_APPLY) && ch_q && pend_q[1] // see [RULE9]
		|=> POS1_O == $past(preset_q[1]) && !pend_q[1] [*2])
		else $error("preset not applied");
	align_foreign_a: assert property ($rose(ALIGNED_O) |-> $past(kind_q[0]) == XD_FOREIGN) // see [RULE18]
		else $error("alignment on non foreign transducer");
	pass_time_a: assert property ((st_q == ST_IDLE) |-> ##[1:60] (st_q == ST_APPLY))
		else $error("scaling pass overran");

	preset_seen_c: cover property ((st_q == ST_APPLY) && ch_q && pend_q[1]);
	reject_seen_c: cover property (BLK_STB_I && !blk_ok);
	align_seen_c: cover property ($rose(ALIGNED_O));
	latch_seen_c: cover property (FAULT_O[1] && latch_q[1] && !lvl_q[1]);
endmodule

`default_nettype wire

//--- test/rps_top_test.sv
// Purpose: self checking bench for resolver position scaling
// Assumes: blocks land one clock after the strobe edge
// Notes: channel 1 carries the scaling checks but one matched dual check on channel 0, it always scales as single
`default_nettype none
module rps_top_test
	import rps_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ==============================================================
	// stimulus and observed signals
	logic clk = 1'b0, rst_b = 1'b0, stb = 1'b0, slave = 1'b0, set_ch = 1'b0, latch = 1'b0;
	logic dir = 1'b0, gear = 1'b0, mch = 1'b1, mpre = 1'b0, mclr = 1'b0, mled = 1'b1;
	logic [2:0] kind = 3'h0;
	logic [15:0] trim = 16'h0, rnd = 16'h29d3, trim_o;
	logic [13:0] mv = 14'h0cb2, hz = 14'h09c4, mv_o, hz_o;
	logic [8:0] r0 = 9'h05f, r1 = 9'h05f, r0_o, r1_o;
	logic [1:0] xk = 2'h0, fpin = 2'h0, fw, flt_o, led_o;
	logic [TRN_W-1:0] xt = 11'h1, tu = 11'h1, turn = 11'h0, ct;
	logic [FSC_W-1:0] fsc = 27'h400, pre = 27'h0, p0_o, p1_o;
	logic [ANG_W-1:0] a0 = 16'h0, a1 = 16'h1234, an0, an1;
	logic slave_o, vern_o, err_o, algn_o;
	int n_errors = 0, compares = 0;
	always #4 clk = ~clk;
	// ==============================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// reverse sense counts down from full scale, kept modulo full scale
	function automatic logic [FSC_W-1:0] exp_pos(input logic [ANG_W-1:0] a,
		input logic [FSC_W-1:0] f, input logic d);
		logic [63:0] r;
		r = (64'(a) * f) >> 16;
		if (d) r = (64'(f) - r) % f;
		return r[FSC_W-1:0];
	endfunction
	task automatic report_and_stop();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		compares++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch at %0t: %s got %0h want %0h", $time, what, got, want);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one whole block per strobe, fields already stable
	task automatic blk(input logic [2:0] k);
		@(posedge clk) #1;
		kind = k;
		stb = 1'b1;
		@(posedge clk) #1;
		stb = 1'b0;
	endtask
	task automatic setup(input logic c, input logic [1:0] k, input int x, t, f, p, input logic bad);
		set_ch = c;
		xk = k;
		xt = TRN_W'(x);
		tu = TRN_W'(t);
		fsc = FSC_W'(f);
		pre = FSC_W'(p);
		blk(3'h2);
		check(err_o, bad, "setup refusal");
	endtask
	// positions come round once per pass, so poll under a bound
	task automatic wait_pos(input logic c, input logic [FSC_W-1:0] e);
		int i;
		for (i = 0; i < 400; i++) begin
			if ((c ? p1_o : p0_o) === e) break;
			cyc(1);
		end
		check(c ? p1_o : p0_o, e, "position");
		if (i == 400) report_and_stop();
	endtask
	// ==============================================================
	// main sequence
	initial begin
		int i;
		logic [13:0] em, eh;
		logic [FSC_W-1:0] e;
		cyc(8);
		check({mv_o, hz_o}, {REF_MV_DEF, REF_HZ_DEF}, "ref default");
		check({r0_o, r1_o}, {RATIO_DEF, RATIO_DEF}, "ratio default");
		check({slave_o, err_o, algn_o, led_o, p1_o}, 32'h3 << 27, "flags default");
		rst_b = 1'b1;
		for (i = 0; i < 5; i++) begin
			mv = (i == 0) ? REF_MV_MIN : (i == 1) ? REF_MV_MAX : 14'(REF_MV_MIN + rnd % 11201);
			hz = (i == 0) ? REF_HZ_MAX : (i == 1) ? REF_HZ_MIN : 14'(REF_HZ_MIN + rnd % 9601);
			r0 = 9'(RATIO_MIN + rnd % 291);
			r1 = (i == 0) ? RATIO_MIN : 9'(RATIO_MAX - rnd % 291);
			slave = rnd[3];
			rnd = lfsr(rnd);
			blk(3'h1);
			check({mv_o, hz_o}, {mv, hz}, "reference");
			check({r0_o, r1_o, slave_o}, {r0, r1, slave}, "ratio and role");
		end
		em = mv;
		eh = hz;
		for (i = 0; i < 5; i++) begin
			case (i)
				0: mv = REF_MV_MAX + 14'h1;
				1: mv = REF_MV_MIN - 14'h1;
				2: hz = REF_HZ_MAX + 14'h1;
				3: r0 = RATIO_MIN - 9'h1;
				default: hz = REF_HZ_MIN - 14'h1;
			endcase
			blk(i == 4 ? 3'h5 : 3'h1);
			check({err_o, mv_o, hz_o}, {1'b1, em, eh}, "config refusal");
			mv = em;
			hz = eh;
			r0 = RATIO_MIN;
		end
		trim = rnd;
		blk(3'h0);
		check({err_o, trim_o}, {1'b0, trim}, "calibration");
		blk(3'h3);
		check({err_o, algn_o}, 2'b10, "align on single");
		$display("test config done");
		setup(1'b0, 2'h0, 1, 1, 1, 0, 1'b1);
		setup(1'b0, 2'h0, 1, 1, 65537, 0, 1'b1);
		setup(1'b0, 2'h0, 1, 1, 500, 500, 1'b1);
		setup(1'b0, 2'h1, 150, 1, 1000, 0, 1'b1);
		setup(1'b0, 2'h1, 100, 3, 1000, 0, 1'b1);
		setup(1'b0, 2'h1, 1000, 5, 1000, 0, 1'b1);
		setup(1'b0, 2'h1, 100, 4, 262145, 0, 1'b1);
		setup(1'b0, 2'h1, 1800, 10, 65537, 0, 1'b1);
		setup(1'b0, 2'h2, 129, 1, 1000, 0, 1'b1);
		setup(1'b0, 2'h2, 64, 3, 1000, 0, 1'b1);
		setup(1'b0, 2'h2, 64, 4, 262145, 0, 1'b1);
		setup(1'b1, 2'h1, 100, 1, 1000, 0, 1'b1);
		setup(1'b0, 2'h3, 1, 1, 1000, 0, 1'b1);
		setup(1'b0, 2'h1, 180, 36, 2359296, 0, 1'b0);
		setup(1'b0, 2'h1, 1800, 10, 65536, 0, 1'b0);
		gear = 1'b1;
		setup(1'b0, 2'h2, 128, 32, 2097152, 0, 1'b0);
		check(vern_o, 1'b1, "vernier");
		gear = 1'b0;
		setup(1'b0, 2'h2, 2, 1, 2, 1, 1'b0);
		blk(3'h3);
		check({err_o, algn_o, vern_o}, 3'b010, "align foreign");
		setup(1'b0, 2'h1, 100, 4, 4000, 0, 1'b0);
		turn = 11'h5;
		a0 = 16'h8000;
		wait_pos(1'b0, 27'h5dc);
		for (i = 0; i < 4; i++) begin
			a1 = rnd | 16'h0001;
			dir = rnd[1];
			rnd = lfsr(rnd);
			e = (i == 0) ? 27'h10000 : 27'(2 + rnd % 65535);
			setup(1'b1, 2'h0, 1, 1, e, 0, 1'b0);
			wait_pos(1'b1, exp_pos(a1, e, dir));
		end
		dir = 1'b0;
		setup(1'b1, 2'h0, 1, 1, 1000, 777, 1'b0);
		// a pass sampled before the new full scale would skew the hidden offset
		wait_pos(1'b1, exp_pos(a1, 27'h3e8, 1'b0));
		mpre = 1'b1;
		blk(3'h4);
		mpre = 1'b0;
		wait_pos(1'b1, 27'h309);
		e = exp_pos(a1, 27'h3e8, 1'b0);
		a1 = a1 + 16'h2345;
		e = 27'((exp_pos(a1, 27'h3e8, 1'b0) + 27'h3e8 - e + 27'h309) % 27'h3e8);
		wait_pos(1'b1, e);
		$display("test position done");
		for (i = 0; i < 2; i++) begin
			latch = (i == 0);
			setup(1'b1, 2'h0, 1, 1, 1000, 0, 1'b0);
			fpin = 2'b10;
			cyc(10);
			check(flt_o, 2'b10, "fault seen");
			fpin = 2'b00;
			cyc(10);
			check(flt_o, {latch, 1'b0}, "fault after pin");
			{mclr, mled} = {latch, ~latch};
			blk(3'h4);
			cyc(2);
			check({flt_o, led_o}, {2'b00, ~latch, 1'b1}, "clear and led");
		end
		$display("test fault done");
		report_and_stop();
	end
	// ==============================================================
	// design and transducer model
	rps_xdcr_model i_rps_xdcr_model (.clk_i(clk), .ang0_i(a0), .ang1_i(a1), .turn_i(turn),
		.flt_i(fpin), .ang0_o(an0), .ang1_o(an1), .turn_o(ct), .flt_o(fw));
	rps_top i_rps_top (.CORE_CLK_I(clk), .RST_B_I(rst_b), .BLK_STB_I(stb), .BLK_KIND_I(kind),
		.CAL_TRIM_I(trim), .REF_MV_I(mv), .REF_HZ_I(hz), .RATIO0_I(r0), .RATIO1_I(r1),
		.SLAVE_I(slave), .SET_CH_I(set_ch), .XD_KIND_I(xk), .LATCH_I(latch), .DIR_I(dir),
		.GEAR_I(gear), .XTYPE_I(xt), .TURNS_I(tu), .FSC_I(fsc), .PRESET_I(pre),
		.MEAS_CH_I(mch), .MEAS_PRESET_I(mpre), .MEAS_CLR_I(mclr), .MEAS_LED_I(mled),
		.ANGLE0_I(an0), .ANGLE1_I(an1), .COARSE_TURN_I(ct), .FAULT_I(fw),
		.CAL_TRIM_O(trim_o), .REF_MV_O(mv_o), .REF_HZ_O(hz_o), .RATIO0_O(r0_o),
		.RATIO1_O(r1_o), .SLAVE_O(slave_o), .VERNIER_O(vern_o), .POS0_O(p0_o), .POS1_O(p1_o),
		.FAULT_O(flt_o), .LED_O(led_o), .CFG_ERR_O(err_o), .ALIGNED_O(algn_o));
endmodule
`default_nettype wire

//--- test/rps_xdcr_model.sv
// Purpose: transducer side model, demodulated angles, coarse turn and fault pins
// Assumes: demodulation already done on the core clock
// Notes: fault pins are asynchronous wires and move off the clock edge
`default_nettype none
module rps_xdcr_model
	import rps_pkg::*;
(
	input wire logic clk_i,
	input wire logic [ANG_W-1:0] ang0_i,
	input wire logic [ANG_W-1:0] ang1_i,
	input wire logic [TRN_W-1:0] turn_i,
	input wire logic [1:0] flt_i,
	output logic [ANG_W-1:0] ang0_o,
	output logic [ANG_W-1:0] ang1_o,
	output logic [TRN_W-1:0] turn_o,
	output logic [1:0] flt_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==============================================================
	// shaft outputs, one clock behind the bench's shaft setting
	always @(posedge clk_i) begin
		ang0_o <= ang0_i;
		ang1_o <= ang1_i;
		turn_o <= turn_i;
	end
	// fault wire settles a few ns late, so the synchroniser sees a real edge
	always @(flt_i) flt_o <= #3 flt_i;
	initial flt_o = 2'h0;
endmodule
`default_nettype wire
